// >>> dlb_regs.svh
// offsets, positions, reset values and counts of the log builder
`ifndef DLB_REGS_SVH
`define DLB_REGS_SVH
// -----------------------------------------------------------------
// log addresses and log geometry
// -----------------------------------------------------------------
`define DLB_LOG_ERR 8'h02
`define DLB_LOG_ST 8'h06
`define DLB_ERR_SLOTS 8'hFF
`define DLB_ERR_SECTS 8'h33
`define DLB_SLOTS_SECT 8'h05
`define DLB_SLOT_BYTES 7'h5A
`define DLB_SLOT_LAST 7'h59
`define DLB_SECT_BYTES 15'h01C2
`define DLB_ST_ENTRIES 5'h15
`define DLB_ST_BYTES 7'h18
`define DLB_ST_LAST 7'h17
// -----------------------------------------------------------------
// byte positions inside a 512-byte sector
// -----------------------------------------------------------------
`define DLB_DATA_START 10'h002
`define DLB_ERR_END 10'h1C4
`define DLB_CNT_LO 10'h1C4
`define DLB_CNT_HI 10'h1C5
`define DLB_ST_END 10'h1FA
`define DLB_ST_IDX_POS 10'h1FC
`define DLB_LAST_POS 10'h1FF
// -----------------------------------------------------------------
// fixed values and storage layout
// -----------------------------------------------------------------
`define DLB_ERR_VER 8'h01
`define DLB_ST_REV 16'h0001
`define DLB_HW_RESET 8'hFF
`define DLB_CNT_MAX 16'hFFFF
`define DLB_ST_BASE 15'h5A00
`define DLB_MEM_DEPTH 15'h5BF8
`endif

// >>> dlb_pkg.sv
// types shared by the log builder modules
package dlb_pkg;
  // -----------------------------------------------------------------
  // enumerations
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    DLB_IDLE = 2'b00,
    DLB_WR_ERR = 2'b01,
    DLB_WR_ST = 2'b10,
    DLB_RD = 2'b11
  } dlb_fsm_t;
  typedef enum logic [2:0] {
    DLB_MEDIA = 3'b000,
    DLB_SERVO = 3'b001,
    DLB_WFAULT = 3'b010,
    DLB_IDNF = 3'b011,
    DLB_BAD_CMD = 3'b100,
    DLB_BAD_PARAM = 3'b101,
    DLB_BAD_ADDR = 3'b110,
    DLB_OTHER = 3'b111
  } dlb_err_class_t;
  // -----------------------------------------------------------------
  // records, lowest field is byte 0 of the image
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ts;
    logic [7:0] cmd, dev_head, lba_hi, lba_mid, lba_lo, count, feat;
    logic [7:0] dev_ctl;
  } dlb_cmd_rec_t;
  typedef struct packed {
    logic hw_reset;
    dlb_cmd_rec_t rec;
  } dlb_cmd_in_t;
  typedef struct packed {
    logic [7:0] state, status, dev_head, lba_hi, lba_mid, lba_lo, count;
    logic [7:0] error;
  } dlb_err_rec_t;
  typedef struct packed {
    logic ext_addr;
    dlb_err_class_t cls;
    dlb_err_rec_t rec;
  } dlb_err_in_t;
  typedef struct packed {
    logic [31:0] fail_lba;
    logic [7:0] chkpt;
    logic [15:0] hours;
    logic [7:0] status, lba_lo;
  } dlb_st_rec_t;
  typedef struct packed {
    logic ext_addr;
    dlb_st_rec_t rec;
  } dlb_st_in_t;
  typedef struct packed {
    logic [7:0] log_addr;
    logic [7:0] sector;
  } dlb_rd_req_t;
  typedef struct packed {
    logic use_mem;
    logic [7:0] cbyte;
  } dlb_src_t;
  // -----------------------------------------------------------------
  // module state
  // -----------------------------------------------------------------
  typedef struct packed {
    dlb_fsm_t fsm;
    logic rdy, rd_err;
    dlb_cmd_rec_t [4:0] hist;
    dlb_err_rec_t err;
    dlb_st_rec_t strec;
    logic [7:0] err_idx;
    logic err_full;
    logic [15:0] err_cnt;
    logic [4:0] st_idx;
    logic st_full;
    logic [7:0] wr_idx;
    logic [6:0] wr_off;
    logic [14:0] wr_addr;
    logic rd_kind, sec0;
    logic [9:0] pos;
    logic [6:0] off;
    logic [7:0] elem;
    logic [14:0] ma;
    logic d_valid, d_last;
    dlb_src_t d_src;
  } dlb_core_state_t;
  typedef struct packed {
    logic [7:0] sum;
    logic ov, ol;
    logic [7:0] ob;
  } dlb_sum_state_t;
endpackage

// >>> dlb_mem.sv
// byte store for error slots and self-test descriptors
`timescale 1ns/100ps
`include "dlb_regs.svh"
module dlb_mem
  import dlb_pkg::*;
(
  input wire logic core_clk,
  input wire logic we,
  input wire logic [14:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [14:0] raddr,
  output logic [7:0] rdata
);
  // -----------------------------------------------------------------
  // storage, no reset: unwritten slots are masked by the reader
  // -----------------------------------------------------------------
  logic [7:0] mem_reg [0:`DLB_MEM_DEPTH-1];
  logic [7:0] rdata_reg;

  // one write port, registered read port
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata_reg <= mem_reg[raddr];
  end

  assign rdata = rdata_reg;
endmodule

// >>> dlb_sum_out.sv
// sector output stage that closes each sector with its checksum
`timescale 1ns/100ps
`include "dlb_regs.svh"
module dlb_sum_out
  import dlb_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic in_last,
  output logic out_valid,
  output logic [7:0] out_byte,
  output logic out_last
);
  dlb_sum_state_t r_reg, r_next;
  logic [7:0] osum_reg;
  logic [9:0] ocnt_reg;

  // -----------------------------------------------------------------
  // checksum: last byte replaced by the negated running sum
  // -----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.ov = in_valid;
    r_next.ol = in_valid && in_last;
    r_next.ob = in_byte;
    if (in_valid && in_last) begin
      r_next.ob = 8'h00 - r_reg.sum;
      r_next.sum = 8'h00;
    end else if (in_valid) begin
      r_next.sum = r_reg.sum + in_byte;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign out_valid = r_reg.ov;
  assign out_byte = r_reg.ob;
  assign out_last = r_reg.ol;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // independent sum and length of what actually leaves
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      osum_reg <= 8'h00;
      ocnt_reg <= 10'h000;
    end else if (r_reg.ov && r_reg.ol) begin
      osum_reg <= 8'h00;
      ocnt_reg <= 10'h000;
    end else if (r_reg.ov) begin
      osum_reg <= osum_reg + r_reg.ob;
      ocnt_reg <= ocnt_reg + 10'h001;
    end
  end

  sector_sum_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (out_valid && out_last) |-> (8'(osum_reg + out_byte) == 8'h00))
    else $error("sector bytes do not sum to zero");

  sector_len_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (out_valid && out_last) |-> (ocnt_reg == `DLB_LAST_POS))
    else $error("sector is not 512 bytes long");
endmodule

// >>> dlb_log_builder.sv
// error log and self-test log builder with sector readout
`timescale 1ns/100ps
`include "dlb_regs.svh"
// Notes on behaviour
// - error log at 02h, self-test log at 06h
// - error log keeps last 255 errors
// - error log spans at most 51 sectors
// - only 28-bit errors enter the error log
// - device faults logged, rejected commands not
// - when full, overwrite oldest slot, wrapping
// - slots never written read as zeros
// - first sector byte 0 is version 01h
// - byte 1 indexes newest slot, 1 to 255
// - five 90-byte slots from byte 2
// - sector n holds slots 5n+1 to 5n+5
// - first sector bytes 452-453 saturating lifetime error count
// - byte 511 makes sector sum to zero
// - self-test log keeps 28-bit results only
// - self-test bytes 0-1 hold revision 0001h
// - 24-byte descriptors from byte 2 to 505
// - byte 508 index, zero empty, wraps to one
// - unused descriptors read as zeros
// - descriptor: lba low, status, hours, checkpoint
// - descriptor bytes 5-8 hold failing address
// - slot: five command records, then error record
// - hardware reset record: FFh and timestamp
module dlb_log_builder
  import dlb_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire dlb_cmd_in_t cmd_in,
  input wire logic err_valid,
  input wire dlb_err_in_t err_in,
  input wire logic st_valid,
  input wire dlb_st_in_t st_in,
  input wire logic rd_valid,
  input wire dlb_rd_req_t rd_req,
  output logic log_rdy,
  output logic rd_err,
  output logic rd_dvalid,
  output logic [7:0] rd_data,
  output logic rd_last
);
  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  // only faults the device owns; bad commands never log
  function automatic logic loggable(input dlb_err_class_t c);
    loggable = (c == DLB_MEDIA) || (c == DLB_SERVO) ||
      (c == DLB_WFAULT) || (c == DLB_IDNF);
  endfunction

  // slot or descriptor area of a sector
  function automatic logic in_data(input logic kind,
                                   input logic [9:0] p);
    in_data = (p >= `DLB_DATA_START) &&
      (p < (kind ? `DLB_ERR_END : `DLB_ST_END));
  endfunction

  // saturating lifetime count
  function automatic logic [15:0] sat_inc(input logic [15:0] c);
    sat_inc = (c == `DLB_CNT_MAX) ? c : c + 16'h0001;
  endfunction

  // -----------------------------------------------------------------
  // state and images
  // -----------------------------------------------------------------
  dlb_core_state_t s_reg, s_next;
  dlb_cmd_rec_t cmd_rec;
  logic err_take;
  logic st_take;
  logic rd_in;
  logic rd_ev;
  logic [89:0][7:0] slot_img;
  logic [23:0][7:0] st_img;
  logic mem_we;
  logic [14:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem_rd;
  logic [7:0] out_byte;

  // a hardware reset keeps only its marker and timestamp
  assign cmd_rec = cmd_in.hw_reset ?
    {cmd_in.rec.ts, 56'h0, `DLB_HW_RESET} : cmd_in.rec;

  // accepted events; extended-address entries are dropped
  assign err_take = err_valid && !err_in.ext_addr &&
    loggable(err_in.cls);
  assign st_take = st_valid && !st_in.ext_addr;

  // oldest command first, failing one last, then error record
  assign slot_img = {16'h0000, s_reg.err.state, 8'h00, 144'h0,
    s_reg.err[55:0], 8'h00, s_reg.hist};
  // lba low, status, hours, checkpoint, failing address
  assign st_img = {120'h0, s_reg.strec};

  // read position decode and slot-written check
  assign rd_in = in_data(s_reg.rd_kind, s_reg.pos);
  assign rd_ev = s_reg.rd_kind ?
    (s_reg.err_full || (s_reg.elem < s_reg.err_idx)) :
    (s_reg.st_full || (s_reg.elem < {3'b000, s_reg.st_idx}));

  // memory write port follows the write states
  assign mem_we = (s_reg.fsm == DLB_WR_ERR) ||
    (s_reg.fsm == DLB_WR_ST);
  assign mem_wa = s_reg.wr_addr + 15'(s_reg.wr_off);
  assign mem_wd = (s_reg.fsm == DLB_WR_ERR) ?
    slot_img[s_reg.wr_off] : st_img[s_reg.wr_off[4:0]];

  // unwritten slots are masked here instead of cleared
  assign out_byte = s_reg.d_src.use_mem ? mem_rd :
    s_reg.d_src.cbyte;

  // -----------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rd_err = 1'b0;
    s_next.d_valid = 1'b0;
    s_next.d_last = 1'b0;
    s_next.d_src = '0;
    case (s_reg.fsm)
      DLB_IDLE: begin
        // history only moves while idle so a slot image is stable
        if (s_reg.rdy && cmd_valid) begin
          s_next.hist = {cmd_rec, s_reg.hist[4:1]};
        end
        // extended-address faults still count toward the lifetime
        if (s_reg.rdy && err_valid && err_in.ext_addr &&
            loggable(err_in.cls)) begin
          s_next.err_cnt = sat_inc(s_reg.err_cnt);
        end
        if (s_reg.rdy && err_take) begin
          s_next.err = err_in.rec;
          s_next.wr_idx = (s_reg.err_idx == `DLB_ERR_SLOTS) ?
            8'h01 : s_reg.err_idx + 8'h01;
          s_next.wr_addr = 15'(s_next.wr_idx - 8'h01) *
            15'(`DLB_SLOT_BYTES);
          s_next.wr_off = 7'h00;
          s_next.fsm = DLB_WR_ERR;
        end else if (s_reg.rdy && st_take) begin
          s_next.strec = st_in.rec;
          s_next.wr_idx = {3'b000, (s_reg.st_idx == `DLB_ST_ENTRIES) ?
            5'h01 : s_reg.st_idx + 5'h01};
          s_next.wr_addr = `DLB_ST_BASE + 15'(s_next.wr_idx - 8'h01) *
            15'(`DLB_ST_BYTES);
          s_next.wr_off = 7'h00;
          s_next.fsm = DLB_WR_ST;
        end else if (s_reg.rdy && rd_valid) begin
          s_next.pos = 10'h000;
          s_next.off = 7'h00;
          if (rd_req.log_addr == `DLB_LOG_ERR &&
              rd_req.sector < `DLB_ERR_SECTS) begin
            s_next.rd_kind = 1'b1;
            s_next.sec0 = (rd_req.sector == 8'h00);
            s_next.elem = 8'(rd_req.sector * `DLB_SLOTS_SECT);
            s_next.ma = 15'(rd_req.sector) * `DLB_SECT_BYTES;
            s_next.fsm = DLB_RD;
          end else if (rd_req.log_addr == `DLB_LOG_ST &&
                       rd_req.sector == 8'h00) begin
            s_next.rd_kind = 1'b0;
            s_next.sec0 = 1'b1;
            s_next.elem = 8'h00;
            s_next.ma = `DLB_ST_BASE;
            s_next.fsm = DLB_RD;
          end else begin
            s_next.rd_err = 1'b1;
          end
        end
      end
      DLB_WR_ERR, DLB_WR_ST: begin
        s_next.wr_off = s_reg.wr_off + 7'h01;
        // index, count and full flag land with the final byte
        if (s_reg.fsm == DLB_WR_ERR &&
            s_reg.wr_off == `DLB_SLOT_LAST) begin
          s_next.err_idx = s_reg.wr_idx;
          if (s_reg.wr_idx == `DLB_ERR_SLOTS) begin
            s_next.err_full = 1'b1;
          end
          s_next.err_cnt = sat_inc(s_reg.err_cnt);
          s_next.fsm = DLB_IDLE;
        end
        if (s_reg.fsm == DLB_WR_ST &&
            s_reg.wr_off == `DLB_ST_LAST) begin
          s_next.st_idx = s_reg.wr_idx[4:0];
          if (s_reg.wr_idx[4:0] == `DLB_ST_ENTRIES) begin
            s_next.st_full = 1'b1;
          end
          s_next.fsm = DLB_IDLE;
        end
      end
      DLB_RD: begin
        s_next.d_valid = 1'b1;
        s_next.d_last = (s_reg.pos == `DLB_LAST_POS);
        s_next.d_src.use_mem = rd_in && rd_ev;
        // fixed header and trailer bytes, all others zero
        if (!rd_in && s_reg.sec0) begin
          if (s_reg.pos == 10'h000) begin
            s_next.d_src.cbyte = s_reg.rd_kind ?
              `DLB_ERR_VER : 8'(`DLB_ST_REV);
          end else if (s_reg.pos == 10'h001) begin
            s_next.d_src.cbyte = s_reg.rd_kind ?
              s_reg.err_idx : 8'(`DLB_ST_REV >> 8);
          end else if (s_reg.rd_kind &&
                       s_reg.pos == `DLB_CNT_LO) begin
            s_next.d_src.cbyte = s_reg.err_cnt[7:0];
          end else if (s_reg.rd_kind &&
                       s_reg.pos == `DLB_CNT_HI) begin
            s_next.d_src.cbyte = s_reg.err_cnt[15:8];
          end else if (!s_reg.rd_kind &&
                       s_reg.pos == `DLB_ST_IDX_POS) begin
            s_next.d_src.cbyte = {3'b000, s_reg.st_idx};
          end
        end
        // slots of a sector are contiguous in the store
        if (rd_in) begin
          s_next.ma = s_reg.ma + 15'h0001;
          if (s_reg.off == (s_reg.rd_kind ?
              `DLB_SLOT_LAST : `DLB_ST_LAST)) begin
            s_next.off = 7'h00;
            s_next.elem = s_reg.elem + 8'h01;
          end else begin
            s_next.off = s_reg.off + 7'h01;
          end
        end
        s_next.pos = s_reg.pos + 10'h001;
        if (s_reg.pos == `DLB_LAST_POS) begin
          s_next.fsm = DLB_IDLE;
        end
      end
      default: begin
        s_next.fsm = DLB_IDLE;
      end
    endcase
    // reads and writes never overlap, so no torn sector is seen
    s_next.rdy = (s_next.fsm == DLB_IDLE);
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // -----------------------------------------------------------------
  // storage and output stage
  // -----------------------------------------------------------------
  dlb_mem u_mem (
    .core_clk(core_clk),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr(s_reg.ma),
    .rdata(mem_rd)
  );

  // checksum is taken on the fly, always matching the data sent
  dlb_sum_out u_out (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(s_reg.d_valid),
    .in_byte(out_byte),
    .in_last(s_reg.d_last),
    .out_valid(rd_dvalid),
    .out_byte(rd_data),
    .out_last(rd_last)
  );

  assign log_rdy = s_reg.rdy;
  assign rd_err = s_reg.rd_err;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  bad_log_a: assert property (
    (s_reg.rdy && !err_take && !st_take && rd_valid &&
     rd_req.log_addr != `DLB_LOG_ERR &&
     rd_req.log_addr != `DLB_LOG_ST) |=> (rd_err && !rd_dvalid))
    else $error("unknown log address not refused");

  sect_limit_a: assert property (
    (s_reg.rdy && !err_take && !st_take && rd_valid &&
     rd_req.log_addr == `DLB_LOG_ERR &&
     rd_req.sector >= `DLB_ERR_SECTS) |=> rd_err)
    else $error("error log sector beyond limit accepted");

  ext_drop_a: assert property (
    (s_reg.rdy && err_valid && err_in.ext_addr)
    |=> (s_reg.fsm != DLB_WR_ERR))
    else $error("extended-address error logged");

  class_drop_a: assert property (
    (s_reg.rdy && err_valid && !loggable(err_in.cls))
    |=> (s_reg.fsm != DLB_WR_ERR && $stable(s_reg.err_cnt)))
    else $error("rejected command logged or counted");

  idx_wrap_a: assert property (
    ($changed(s_reg.err_idx) && $past(s_reg.err_idx) == 8'hFF)
    |-> (s_reg.err_idx == 8'h01 && s_reg.err_full))
    else $error("error index did not wrap to one");

  idx_legal_a: assert property (
    $changed(s_reg.err_idx) |-> (s_reg.err_idx != 8'h00 &&
      $changed(s_reg.err_cnt) || s_reg.err_cnt == `DLB_CNT_MAX))
    else $error("error index moved without a count");

  cnt_sat_a: assert property (
    ($past(s_reg.err_cnt) == `DLB_CNT_MAX) |->
    (s_reg.err_cnt == `DLB_CNT_MAX))
    else $error("lifetime count wrapped");

  st_wrap_a: assert property (
    ($changed(s_reg.st_idx) && $past(s_reg.st_idx) == 5'h15)
    |-> (s_reg.st_idx == 5'h01 && s_reg.st_full))
    else $error("self-test index did not wrap to one");

  unused_zero_a: assert property (
    (s_reg.fsm == DLB_RD && rd_in && !rd_ev)
    |=> (!s_reg.d_src.use_mem && s_reg.d_src.cbyte == 8'h00))
    else $error("unwritten slot not returned as zero");

  version_a: assert property (
    (s_reg.fsm == DLB_RD && s_reg.pos == 10'h000 && s_reg.sec0 &&
     s_reg.rd_kind) |-> ##2 (rd_dvalid && rd_data == 8'h01))
    else $error("error log version byte wrong");

  atomic_upd_a: assert property (
    (s_reg.fsm == DLB_RD) |-> ($stable(s_reg.err_idx) &&
      $stable(s_reg.st_idx) && !mem_we))
    else $error("log changed during a sector read");

  wr_done_a: assert property (
    $rose(s_reg.fsm == DLB_WR_ERR) |-> ##90 (s_reg.fsm == DLB_IDLE))
    else $error("error slot write not 90 bytes");

  err_write_c: cover property ($fell(s_reg.fsm == DLB_WR_ERR));
  st_write_c: cover property ($fell(s_reg.fsm == DLB_WR_ST));
  err_read_c: cover property (rd_dvalid && rd_last);
  err_wrap_c: cover property ($rose(s_reg.err_full));
endmodule

// >>> dlb_host_model.sv
// host model that requests log sectors and gathers their bytes
`timescale 1ns/100ps
module dlb_host_model
  import dlb_pkg::*;
(
  input wire logic core_clk,
  input wire logic log_rdy,
  input wire logic rd_err,
  input wire logic rd_dvalid,
  input wire logic [7:0] rd_data,
  input wire logic rd_last,
  output logic rd_valid,
  output dlb_rd_req_t rd_req
);
  logic [7:0] sec [0:511];
  int nb, last_at;
  // idle bus shows a pattern, never a stale request
  initial begin
    rd_valid = 1'b0;
    rd_req = 16'h5A5A;
  end
  // request held until the taking edge, then bytes gathered
  task automatic read(input dlb_rd_req_t r, output logic err);
    int w;
    err = 1'b0;
    nb = 0;
    last_at = 0;
    w = 0;
    do begin
      @(negedge core_clk);
      w++;
    end while (log_rdy !== 1'b1 && w < 200);
    @(posedge core_clk);
    rd_valid <= 1'b1;
    rd_req <= r;
    @(posedge core_clk);
    rd_valid <= 1'b0;
    rd_req <= ~r;
    // bounded, a silent block must not hang the host
    repeat (600) begin
      @(negedge core_clk);
      if (rd_err === 1'b1) err = 1'b1;
      if (rd_dvalid === 1'b1) begin
        sec[nb] = rd_data;
        nb++;
      end
      // byte count at the closing pulse, zero if it never came
      if (rd_last === 1'b1) last_at = nb;
      if (err || rd_last === 1'b1) break;
    end
  endtask
endmodule

// >>> dlb_log_builder_tb.sv
// self-checking bench for the log builder
`timescale 1ns/100ps
module dlb_log_builder_tb;
  import dlb_pkg::*;
  logic core_clk = 0;
  logic nrst = 0;
  logic cmd_valid = 0, err_valid = 0, st_valid = 0;
  logic rd_valid, log_rdy, rd_err, rd_dvalid, rd_last;
  logic [7:0] rd_data;
  dlb_cmd_in_t cmd_in = '0;
  dlb_err_in_t err_in = '0;
  dlb_st_in_t st_in = '0;
  dlb_rd_req_t rd_req;
  int failures = 0, n_compared = 0;
  logic [7:0] emem [0:22949];
  logic [7:0] smem [0:503];
  logic [7:0] ex [0:511];
  logic [95:0] hq [0:4];
  logic [7:0] e_idx = 0;
  logic [15:0] e_cnt = 0;
  logic [4:0] s_idx = 0;

  dlb_log_builder dut (.core_clk(core_clk), .nrst(nrst),
    .cmd_valid(cmd_valid), .cmd_in(cmd_in), .err_valid(err_valid),
    .err_in(err_in), .st_valid(st_valid), .st_in(st_in),
    .rd_valid(rd_valid), .rd_req(rd_req), .log_rdy(log_rdy),
    .rd_err(rd_err), .rd_dvalid(rd_dvalid), .rd_data(rd_data),
    .rd_last(rd_last));
  dlb_host_model host (.core_clk(core_clk), .log_rdy(log_rdy),
    .rd_err(rd_err), .rd_dvalid(rd_dvalid), .rd_data(rd_data),
    .rd_last(rd_last), .rd_valid(rd_valid), .rd_req(rd_req));

  always #4 core_clk = ~core_clk;

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bytes differ by position, so a swapped byte cannot pass
  function automatic logic [95:0] mk(input int n);
    for (int i = 0; i < 12; i++) mk[8*i+:8] = 8'(n * 7 + i * 19);
  endfunction
  task automatic issue(input logic c, input logic e, input logic s,
                       input int lo);
    int w;
    w = 0;
    do begin
      @(negedge core_clk);
      w++;
    end while (log_rdy !== 1'b1 && w < 200);
    @(posedge core_clk);
    cmd_valid <= c;
    err_valid <= e;
    st_valid <= s;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    err_valid <= 1'b0;
    st_valid <= 1'b0;
    // busy time of whatever write was taken
    w = 0;
    @(negedge core_clk);
    while (log_rdy !== 1'b1 && w < 200) begin
      w++;
      @(negedge core_clk);
    end
    chk(16'(w), 16'(lo));
  endtask
  task automatic push(input int n, input logic hw);
    logic [95:0] r;
    r = mk(n);
    @(posedge core_clk);
    cmd_in <= {hw, r};
    for (int i = 0; i < 4; i++) hq[i] = hq[i+1];
    hq[4] = hw ? {r[95:64], 56'h0, 8'hFF} : r;
  endtask
  // mirror of the slot store, index and count
  task automatic err_ev(input int n, input dlb_err_class_t c,
                        input logic x, input logic wc);
    logic [63:0] r;
    int b;
    r = 64'(mk(n));
    if (wc) push(n + 500, 1'b0);
    @(posedge core_clk);
    err_in <= {x, c, r};
    issue(wc, 1'b1, 1'b0, (c <= DLB_IDNF && !x) ? 90 : 0);
    if (c <= DLB_IDNF) begin
      if (e_cnt != 16'hFFFF) e_cnt++;
      if (!x) begin
        e_idx = (e_idx == 8'd255) ? 8'd1 : e_idx + 8'd1;
        b = (e_idx - 1) * 90;
        for (int j = 0; j < 90; j++) emem[b+j] = 8'h00;
        for (int j = 0; j < 60; j++) emem[b+j] = hq[j/12][8*(j%12)+:8];
        for (int j = 1; j < 8; j++) emem[b+60+j] = r[8*(j-1)+:8];
        emem[b+87] = r[63:56];
      end
    end
  endtask
  task automatic st_ev(input int n, input logic x);
    logic [95:0] r;
    r = mk(n);
    @(posedge core_clk);
    st_in <= {x, r[71:0]};
    issue(1'b0, 1'b0, 1'b1, x ? 0 : 24);
    if (!x) begin
      s_idx = (s_idx == 5'd21) ? 5'd1 : s_idx + 5'd1;
      for (int j = 0; j < 24; j++)
        smem[(s_idx-1)*24+j] = j < 9 ? r[8*j+:8] : 8'h00;
    end
  endtask
  // expected image built from the mirror, then read and compared
  task automatic rd_chk(input logic [7:0] la, input logic [7:0] s);
    logic err;
    logic [7:0] sum;
    sum = 8'h00;
    foreach (ex[i]) ex[i] = 8'h00;
    ex[0] = 8'h01;
    if (la == 8'h02) begin
      if (s != 8'h00) ex[0] = 8'h00;
      else ex[1] = e_idx;
      if (s == 8'h00) {ex[453], ex[452]} = e_cnt;
      for (int b = 0; b < 450; b++) ex[2+b] = emem[s*450+b];
    end else begin
      for (int b = 0; b < 504; b++) ex[2+b] = smem[b];
      ex[508] = 8'(s_idx);
    end
    for (int i = 0; i < 511; i++) sum += ex[i];
    ex[511] = -sum;
    host.read({la, s}, err);
    chk(err, 1'b0);
    chk(16'(host.nb), 16'h0200);
    chk(16'(host.last_at), 16'h0200);
    for (int i = 0; i < 511; i++) chk(host.sec[i], ex[i]);
    chk(host.sec[511], ex[511]);
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_refuse();
    logic err;
    dlb_rd_req_t bad [4] = '{16'h0300, 16'h0233, 16'h0601, 16'h0900};
    foreach (bad[i]) begin
      host.read(bad[i], err);
      chk(err, 1'b1);
      chk(16'(host.nb), 16'h0000);
    end
  endtask
  task automatic t_errs();
    push(1, 1'b1);
    issue(1'b1, 1'b0, 1'b0, 0);
    push(2, 1'b0);
    issue(1'b1, 1'b0, 1'b0, 0);
    err_ev(10, DLB_MEDIA, 1'b0, 1'b1);
    for (int c = 0; c < 8; c++) err_ev(20 + c, dlb_err_class_t'(c), 0, 0);
    err_ev(40, DLB_MEDIA, 1'b1, 1'b0);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h02, 8'h01);
  endtask
  task automatic t_st();
    for (int n = 0; n < 22; n++) st_ev(100 + n, 1'b0);
    st_ev(200, 1'b1);
    rd_chk(8'h06, 8'h00);
  endtask
  task automatic t_wrap();
    for (int n = 0; n < 256; n++) err_ev(300 + n, DLB_SERVO, 0, n == 0);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h02, 8'h01);
    rd_chk(8'h02, 8'h32);
  endtask

  // main sequence
  initial begin
    foreach (emem[i]) emem[i] = 8'h00;
    foreach (smem[i]) smem[i] = 8'h00;
    foreach (hq[i]) hq[i] = '0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h02, 8'h32);
    rd_chk(8'h06, 8'h00);
    t_refuse();
    t_errs();
    t_st();
    t_wrap();
    end_sim();
  end
  // watchdog, about twice the expected run
  initial begin
    #500000;
    failures++;
    end_sim();
  end
endmodule
